//--- tb_top.sv
// self-checking bench for the timer control block
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   // edge code c: bit 2c says rise counts, bit 2c+1 says fall counts
   localparam logic [7:0] EDGES = 8'b11_00_10_01;
   logic        clk_sys = 1'b0;
   logic        reset = 1'b1;
   logic [7:0]  avs_address = 8'h00;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0]  avs_byteenable = 4'hf;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        debug_halt = 1'b0;
   logic        cap_a_in = 1'b0;
   logic        cap_b_in = 1'b0;
   logic        cal_tick = 1'b0;
   logic        half_a_wave_r;
   logic        half_a_trigger_r;
   logic [31:0] calendar_count_r;
   logic [10:0] irq_enabled_r;
   logic [31:0] rd_data;
   int          error_cnt = 0;
   int          checked = 0;
   int          cyc = 0;
   int          ntr = 0;
   int          nirq = 0;
   // short reload width keeps timeouts a few cycles apart
   tcl_timer_ctrl #(.WIDTH(4)) i_dut (.*);
   always #12.5 clk_sys = ~clk_sys;
   always @(negedge clk_sys)
   begin
      ntr += (half_a_trigger_r === 1'b1);
      nirq += (irq_enabled_r[3] === 1'b1);
   end
   always @(posedge clk_sys)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         error_cnt++;
         $display("mismatch %0t timeout", $time);
         results();
      end
   end
   // ****
   // tasks
   // ****
   task automatic results;
      if (error_cnt == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("mismatch %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // request held until waitrequest is sampled low at a rising edge, released there
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] b);
      @(posedge clk_sys);
      avs_address <= a;
      avs_writedata <= d;
      avs_byteenable <= b;
      avs_write <= w;
      avs_read <= !w;
      do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
      rd_data = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   task automatic ticks(input int k);
      repeat (k)
      begin
         @(posedge clk_sys);
         cal_tick <= 1'b1;
         @(posedge clk_sys);
         cal_tick <= 1'b0;
      end
      repeat (4) @(negedge clk_sys);
   endtask
   // set control and halt, clear status, then let the halves run
   task automatic soak(input logic [31:0] c, input logic h);
      @(posedge clk_sys);
      debug_halt <= h;
      bus(1'b1, 8'h0c, c, 4'hf);
      repeat (2) @(negedge clk_sys);
      bus(1'b0, 8'h1c, 32'h0, 4'hf);
      ntr = 0;
      repeat (60) @(negedge clk_sys);
      bus(1'b0, 8'h1c, 32'h0, 4'hf);
   endtask
   task automatic t_regs;
      bus(1'b0, 8'h0c, 32'h0, 4'hf);
      cmp(rd_data, 32'h0);
      bus(1'b1, 8'h0c, 32'hffffffff, 4'h1);
      bus(1'b0, 8'h0c, 32'h0, 4'hf);
      cmp(rd_data, 32'h7f);
      bus(1'b1, 8'h0c, 32'hffffffff, 4'hf);
      bus(1'b0, 8'h0c, 32'h0, 4'hf);
      cmp(rd_data, 32'h37f);
      bus(1'b1, 8'h18, 32'hffffffff, 4'hf);
      bus(1'b0, 8'h18, 32'h0, 4'hf);
      cmp(rd_data, 32'h70f);
      bus(1'b1, 8'h40, 32'hffffffff, 4'hf);
      bus(1'b0, 8'h40, 32'h0, 4'hf);
      cmp(rd_data, 32'h0);
      bus(1'b1, 8'h0c, 32'h0, 4'hf);
   endtask
   task automatic t_cal;
      bus(1'b1, 8'h18, 32'h8, 4'hf);
      bus(1'b1, 8'h0c, 32'h10, 4'hf);
      nirq = 0;
      ticks(3);
      cmp(calendar_count_r, 32'h3);
      cmp(32'(nirq), 32'h3);
      bus(1'b1, 8'h18, 32'h0, 4'hf);
      nirq = 0;
      ticks(2);
      cmp(32'(nirq), 32'h0);
      @(posedge clk_sys);
      debug_halt <= 1'b1;
      bus(1'b1, 8'h0c, 32'h12, 4'hf);
      ticks(2);
      cmp(calendar_count_r, 32'h5);
      @(posedge clk_sys);
      debug_halt <= 1'b0;
      ticks(1);
      cmp(calendar_count_r, 32'h6);
      bus(1'b1, 8'h0c, 32'h0, 4'hf);
      ticks(2);
      cmp(calendar_count_r, 32'h6);
   endtask
   task automatic t_wave;
      bus(1'b1, 8'h0c, 32'h40, 4'hf);
      repeat (2) @(negedge clk_sys);
      cmp(32'(half_a_wave_r), 32'h1);
      bus(1'b1, 8'h0c, 32'h0, 4'hf);
      repeat (2) @(negedge clk_sys);
      cmp(32'(half_a_wave_r), 32'h0);
   endtask
   task automatic t_run;
      soak(32'h20, 1'b0);
      cmp(32'(ntr != 0) | (rd_data & 32'h5), 32'h0);
      soak(32'h101, 1'b0);
      cmp(32'(ntr != 0) | (rd_data & 32'h5), 32'h5);
      soak(32'h121, 1'b0);
      cmp(32'(ntr != 0), 32'h1);
      soak(32'h323, 1'b1);
      cmp(32'(ntr != 0) | (rd_data & 32'h5), 32'h0);
      soak(32'h121, 1'b1);
      cmp(32'(ntr != 0) | (rd_data & 32'h5), 32'h5);
      debug_halt <= 1'b0;
   endtask
   task automatic t_edge;
      bus(1'b1, 8'h00, 32'h10, 4'hf);
      for (int c = 0; c < 4; c++)
      begin
         bus(1'b1, 8'h0c, {28'h0, c[1:0], 2'b01}, 4'hf);
         bus(1'b0, 8'h1c, 32'h0, 4'hf);
         cap_a_in <= 1'b1;
         repeat (4) @(posedge clk_sys);
         bus(1'b0, 8'h1c, 32'h0, 4'hf);
         cmp(rd_data & 32'h2, {30'h0, EDGES[2*c], 1'b0});
         cap_a_in <= 1'b0;
         repeat (4) @(posedge clk_sys);
         bus(1'b0, 8'h1c, 32'h0, 4'hf);
         cmp(rd_data & 32'h2, {30'h0, EDGES[2*c+1], 1'b0});
      end
      // half b alone in capture mode sees its rising edge
      bus(1'b1, 8'h00, 32'h20, 4'hf);
      bus(1'b0, 8'h00, 32'h0, 4'hf);
      cmp(rd_data, 32'h20);
      bus(1'b1, 8'h0c, 32'h100, 4'hf);
      bus(1'b0, 8'h1c, 32'h0, 4'hf);
      cap_b_in <= 1'b1;
      repeat (4) @(posedge clk_sys);
      bus(1'b0, 8'h1c, 32'h0, 4'hf);
      cmp(rd_data & 32'ha, 32'h8);
   endtask
   initial
   begin
      repeat (16) @(posedge clk_sys);
      reset <= 1'b0;
      t_regs();
      t_cal();
      t_wave();
      t_run();
      t_edge();
      results();
   end
endmodule // tb_top

//--- tcl_chk_asserts.sv
// assertion checker bound to the timer control block
module tcl_chk
(
   // bus side
   input wire logic        clk_sys,
   input wire logic        reset,
   input wire logic [7:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0]  avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   // block side
   input wire logic        debug_halt,
   input wire logic        half_a_wave_r,
   input wire logic        half_a_trigger_r,
   input wire logic [31:0] calendar_count_r,
   input wire logic [10:0] irq_enabled_r
);
   logic [31:0] ctl_r;
   logic [31:0] msk_r;
   wire  [31:0] be = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                      {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
   wire         req = avs_read || avs_write;
   wire         wr = avs_write && !avs_waitrequest;
   wire         rd = avs_read && !avs_waitrequest;
   // calendar must hold when disabled or frozen by a halt
   wire         off = !ctl_r[4] || (ctl_r[1] && debug_halt);
   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (reset);
   // shadow copies follow bus writes lane by lane
   always @(posedge clk_sys)
   begin
      if (reset)
      begin
         ctl_r <= 32'h0;
         msk_r <= 32'h0;
      end
      else if (wr && avs_address == 8'h0c)
         ctl_r <= (avs_writedata & be) | (ctl_r & ~be);
      else if (wr && avs_address == 8'h18)
         msk_r <= (avs_writedata & be) | (msk_r & ~be);
   end
   chk_wait_one: assert property (req && avs_waitrequest |=> !avs_waitrequest)
      else $error("waitrequest high too long");
   chk_ctl_read: assert property (rd && avs_address == 8'h0c |->
      avs_readdata == (ctl_r & 32'h37f)) else $error("control readback wrong");
   chk_mask_read: assert property (rd && avs_address == 8'h18 |->
      avs_readdata == (msk_r & 32'h70f)) else $error("mask readback wrong");
   chk_cal_hold: assert property (off && $past(off) |=> $stable(calendar_count_r))
      else $error("calendar moved while stopped");
   chk_cal_step: assert property ($changed(calendar_count_r) |->
      calendar_count_r == $past(calendar_count_r) + 32'h1) else $error("calendar step wrong");
   chk_trig_gate: assert property (half_a_trigger_r |-> $past(ctl_r[5]) ##1 !half_a_trigger_r)
      else $error("trigger without enable");
   chk_wave_inv: assert property (!ctl_r[0] && $past(!ctl_r[0]) |->
      half_a_wave_r == $past(ctl_r[6])) else $error("wave level wrong");
   chk_irq_gate: assert property (|irq_enabled_r |->
      (irq_enabled_r & ~$past(msk_r[10:0])) == 11'h0) else $error("masked interrupt seen");
   cov_cal: cover property ($changed(calendar_count_r));
   cov_trig: cover property (half_a_trigger_r);
   cov_irq: cover property (|irq_enabled_r);
endmodule // tcl_chk

bind tcl_timer_ctrl tcl_chk i_chk (.*);

//--- tcl_defines.vh
// register offsets, field positions and reset values of the timer control block
`ifndef TCL_DEFINES_VH
`define TCL_DEFINES_VH

// ************************************************************
// register byte offsets
// ************************************************************
`define TCL_OFS_CONFIG      8'h00
`define TCL_OFS_CONTROL     8'h0c
`define TCL_OFS_MASK        8'h18
`define TCL_OFS_STATUS      8'h1c

// ************************************************************
// control field positions
// ************************************************************
`define TCL_CTL_A_RUN       0
`define TCL_CTL_A_FREEZE    1
`define TCL_CTL_A_EDGE_LO   2
`define TCL_CTL_A_EDGE_HI   3
`define TCL_CTL_CAL_EN      4
`define TCL_CTL_A_TRIG      5
`define TCL_CTL_A_INV       6
`define TCL_CTL_RSVD7       7
`define TCL_CTL_B_RUN       8
`define TCL_CTL_B_FREEZE    9
`define TCL_CTL_WMASK       32'h0000037f

// ************************************************************
// edge select codes
// ************************************************************
`define TCL_EDGE_RISE       2'h0
`define TCL_EDGE_FALL       2'h1
`define TCL_EDGE_RSVD       2'h2
`define TCL_EDGE_BOTH       2'h3

// ************************************************************
// reset values and masks
// ************************************************************
`define TCL_CTL_RESET       32'h00000000
`define TCL_MASK_RESET      32'h00000000
`define TCL_MASK_WMASK      32'h0000070f
`define TCL_CFG_RESET       3'h0
`define TCL_CFG_RTC         3'h1

`endif

//--- tcl_half_timer.v
// one half of the timer: down counter with capture edge detection
`include "tcl_defines.vh"

module tcl_half_timer
#(
   parameter WIDTH = 16
)
(
   // clock and reset
   input  wire             clk_sys,
   input  wire             reset,
   // control
   input  wire             run,
   input  wire             freeze_en,
   input  wire             debug_halt,
   input  wire             capture_mode,
   input  wire [1:0]       edge_sel,
   input  wire [WIDTH-1:0] reload,
   // capture input, already synchronous
   input  wire             cap_in,
   // results
   output reg  [WIDTH-1:0] count_r,
   output reg              event_r,
   output reg              timeout_r
);

   reg              cap_prev_r;
   reg              edge_hit;
   wire             halted;

   assign halted = freeze_en & debug_halt;

   always @*
   begin
      case (edge_sel)
         `TCL_EDGE_RISE: edge_hit = cap_in & ~cap_prev_r;
         `TCL_EDGE_FALL: edge_hit = ~cap_in & cap_prev_r;
         `TCL_EDGE_BOTH: edge_hit = cap_in ^ cap_prev_r;
         default:        edge_hit = 1'b0;   // reserved code sees no events
      endcase
   end

   always @(posedge clk_sys)
   begin
      if (reset)
      begin
         count_r    <= {WIDTH{1'b0}};
         cap_prev_r <= 1'b0;
         event_r    <= 1'b0;
         timeout_r  <= 1'b0;
      end
      else
      begin
         cap_prev_r <= cap_in;
         event_r    <= 1'b0;
         timeout_r  <= 1'b0;
         if (!run)
            count_r <= reload;
         else if (!halted)
         begin
            if (capture_mode)
            begin
               if (edge_hit)
               begin
                  event_r <= 1'b1;
                  count_r <= count_r - {{(WIDTH-1){1'b0}}, 1'b1};
               end
            end
            else if (count_r == {WIDTH{1'b0}})
            begin
               timeout_r <= 1'b1;
               count_r   <= reload;
            end
            else
               count_r <= count_r - {{(WIDTH-1){1'b0}}, 1'b1};
         end
      end
   end

endmodule // tcl_half_timer

//--- tcl_timer_ctrl.v
// timer control register, interrupt mask and the two timer halves behind them
//
// Behaviour
// - bit 9 enables half b debug freeze
// - bit 8 runs half b
// - bit 7 reserved, reads zero
// - bit 6 inverts half a wave
// - bit 5 gates half a trigger out
// - bit 4 lets calendar count advance
// - bits 3:2 pick half a capture edge
// - bit 1 enables half a debug freeze
// - bit 0 runs half a
// - mask bit one enables interrupt source
`include "tcl_defines.vh"

module tcl_timer_ctrl
#(
   parameter WIDTH = 16
)
(
   // clock and reset
   input  wire             clk_sys,
   input  wire             reset,
   // avalon-mm slave
   input  wire [7:0]       avs_address,
   input  wire             avs_read,
   input  wire             avs_write,
   input  wire [31:0]      avs_writedata,
   input  wire [3:0]       avs_byteenable,
   output reg  [31:0]      avs_readdata,
   output wire             avs_waitrequest,
   // debug, capture and calendar tick inputs
   input  wire             debug_halt,
   input  wire             cap_a_in,
   input  wire             cap_b_in,
   input  wire             cal_tick,
   // outputs
   output reg              half_a_wave_r,
   output reg              half_a_trigger_r,
   output reg  [31:0]      calendar_count_r,
   output reg  [10:0]      irq_enabled_r
);

   // ************************************************************
   // registers
   // ************************************************************
   reg  [31:0]      timer_control;
   reg  [31:0]      interrupt_mask;
   reg  [2:0]       timer_config_reg;
   reg  [3:0]       mode_r;
   reg              ack_r;
   reg  [31:0]      wmask;
   reg  [31:0]      rd_nxt;
   reg  [7:0]       sticky_r;
   wire [WIDTH-1:0] count_a;
   wire             ev_a;
   wire             ev_b;
   wire             to_a;
   wire             to_b;
   wire             req;
   wire             wr_go;
   wire             half_a_run;
   wire             half_b_run;
   wire             half_a_debug_freeze;
   wire             half_b_debug_freeze;
   wire             half_a_wave_invert;
   wire             half_a_trigger_out_enable;
   wire             calendar_count_enable;
   wire [1:0]       half_a_edge_select;

   // one wait cycle per access keeps read data registered
   assign req             = avs_read | avs_write;
   assign avs_waitrequest = req & ~ack_r;
   assign wr_go           = avs_write & ack_r;

   assign half_a_run                = timer_control[`TCL_CTL_A_RUN];
   assign half_a_debug_freeze       = timer_control[`TCL_CTL_A_FREEZE];
   assign half_a_edge_select        = timer_control[`TCL_CTL_A_EDGE_HI:`TCL_CTL_A_EDGE_LO];
   assign calendar_count_enable     = timer_control[`TCL_CTL_CAL_EN];
   assign half_a_trigger_out_enable = timer_control[`TCL_CTL_A_TRIG];
   assign half_a_wave_invert        = timer_control[`TCL_CTL_A_INV];
   assign half_b_run                = timer_control[`TCL_CTL_B_RUN];
   assign half_b_debug_freeze       = timer_control[`TCL_CTL_B_FREEZE];

   always @*
   begin
      wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
               {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
   end

   // ************************************************************
   // bus slave
   // ************************************************************
   always @(posedge clk_sys)
   begin
      if (reset)
         ack_r <= 1'b0;
      else
         ack_r <= req & ~ack_r;
   end

   always @(posedge clk_sys)
   begin
      if (reset)
      begin
         timer_control    <= `TCL_CTL_RESET;
         interrupt_mask   <= `TCL_MASK_RESET;
         timer_config_reg <= `TCL_CFG_RESET;
         mode_r           <= 4'h0;
      end
      else if (wr_go)
      begin
         case (avs_address)
            `TCL_OFS_CONTROL:   // reserved bits including bit 7 stay zero
               timer_control <= (timer_control & ~(wmask & `TCL_CTL_WMASK)) |
                                (avs_writedata & wmask & `TCL_CTL_WMASK);
            `TCL_OFS_MASK:   // one enables, zero disables
               interrupt_mask <= (interrupt_mask & ~(wmask & `TCL_MASK_WMASK)) |
                                 (avs_writedata & wmask & `TCL_MASK_WMASK);
            `TCL_OFS_CONFIG:
            begin
               if (avs_byteenable[0])
               begin
                  timer_config_reg <= avs_writedata[2:0];
                  mode_r           <= avs_writedata[7:4];
               end
            end
            default:
               mode_r <= mode_r;
         endcase
      end
   end

   always @*
   begin
      case (avs_address)
         `TCL_OFS_CONFIG:  rd_nxt = {24'h000000, mode_r, 1'b0, timer_config_reg};
         `TCL_OFS_CONTROL: rd_nxt = timer_control;
         `TCL_OFS_MASK:    rd_nxt = interrupt_mask;
         `TCL_OFS_STATUS:  rd_nxt = {24'h000000, sticky_r};
         default:          rd_nxt = 32'h00000000;
      endcase
   end

   always @(posedge clk_sys)
   begin
      if (reset)
         avs_readdata <= 32'h00000000;
      else if (avs_read & ~ack_r)
         avs_readdata <= rd_nxt;
   end

   // ************************************************************
   // timer halves
   // ************************************************************
   tcl_half_timer #(.WIDTH(WIDTH)) u_half_a
   (
      .clk_sys      (clk_sys),
      .reset        (reset),
      .run          (half_a_run),
      .freeze_en    (half_a_debug_freeze),
      .debug_halt   (debug_halt),
      .capture_mode (mode_r[0]),
      .edge_sel     (half_a_edge_select),
      .reload       ({WIDTH{1'b1}}),
      .cap_in       (cap_a_in),
      .count_r      (count_a),
      .event_r      (ev_a),
      .timeout_r    (to_a)
   );

   tcl_half_timer #(.WIDTH(WIDTH)) u_half_b
   (
      .clk_sys      (clk_sys),
      .reset        (reset),
      .run          (half_b_run),
      .freeze_en    (half_b_debug_freeze),
      .debug_halt   (debug_halt),
      .capture_mode (mode_r[1]),
      .edge_sel     (`TCL_EDGE_RISE),
      .reload       ({WIDTH{1'b1}}),
      .cap_in       (cap_b_in),
      .count_r      (),
      .event_r      (ev_b),
      .timeout_r    (to_b)
   );

   // ************************************************************
   // outputs
   // ************************************************************
   always @(posedge clk_sys)
   begin
      if (reset)
      begin
         half_a_wave_r    <= 1'b0;
         half_a_trigger_r <= 1'b0;
         calendar_count_r <= 32'h00000000;
         sticky_r         <= 8'h00;
         irq_enabled_r    <= 11'h000;
      end
      else
      begin
         // wave is high in the upper half of the count while half a runs, then optionally inverted
         half_a_wave_r    <= (half_a_run & count_a[WIDTH-1]) ^ half_a_wave_invert;
         half_a_trigger_r <= half_a_trigger_out_enable & to_a;
         if (calendar_count_enable & cal_tick & ~(half_a_debug_freeze & debug_halt))
            calendar_count_r <= calendar_count_r + 32'h00000001;
         // raw event flags; events win over the read-clear of this status
         // clear on the edge that captures readdata, so no flag is dropped unread
         sticky_r <= {4'h0, ev_b, to_b, ev_a, to_a} |
                     (sticky_r & ~((avs_read & ~ack_r &
                                    (avs_address == `TCL_OFS_STATUS)) ? 8'hff : 8'h00));
         // per-source enable seen by the interrupt controller
         irq_enabled_r    <= interrupt_mask[10:0] &
                             {ev_b, 1'b0, to_b, 4'h0,
                              calendar_count_enable & cal_tick, ev_a, 1'b0, to_a};
      end
   end

endmodule // tcl_timer_ctrl
